// ### common/sar_params.svh
// Register indices, field positions and conversion timing of the sequencer
`ifndef SAR_PARAMS_SVH
`define SAR_PARAMS_SVH

// Register indices; byte address is four times the index
`define IDX_RESULT     8'h19
`define IDX_CHANNEL    8'h1b
`define IDX_CTRL_B     8'h1c
`define IDX_CTRL_A     8'h1d

// Control A field positions
`define CA_EN          7
`define CA_SC          6
`define CA_ATE         5
`define CA_FLAG        4
`define CA_IE          3
`define CA_PS_HI       2

// Reset values
`define RST_BYTE       8'h00
`define RST_WORD       32'h0000_0000

// Conversion timing in converter clock cycles from the start edge
`define LEN_NORMAL     5'd13
`define LEN_FIRST      5'd25
`define SH_NORMAL      5'd3
`define SH_FIRST       5'd16
`define SH_AUTO        5'd2

// Trigger source code that means free running
`define SRC_FREERUN    3'h0
// Successive approximation start point
`define SAR_MSB        8'h80

`endif

// ### common/sar_pkg.sv
// Types shared by the conversion sequencer and its prescaler
package sar_pkg;

  typedef enum logic [0:0] {
    PH_IDLE = 1'b0,
    PH_RUN  = 1'b1
  } phase_type;

  typedef struct packed {
    logic [6:0] count;
  } presc_state_type;

  typedef struct packed {
    logic        converter_enable;
    logic        sc;
    logic        ate;
    logic        flag;
    logic        ie;
    logic [2:0]  ps;
    logic [2:0]  ts;
    logic [1:0]  chan_tmp;
    logic [1:0]  chan_act;
    logic [7:0]  result;
    phase_type   phase;
    logic        long_conv;
    logic        auto_conv;
    logic        first;
    logic [4:0]  cnt;
    logic [7:0]  sar;
    logic [7:0]  mask;
    logic [3:0]  trig_dly;
    logic        halt_prev;
    logic        sample;
    logic        irq;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } seq_state_type;

endpackage

// ### rtl/sar_prescaler.sv
// Converter clock prescaler producing a one-cycle tick enable
`timescale 1ns/1ps
`default_nettype none

module sar_prescaler
  import sar_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic       run,
  input  wire logic       restart,
  input  wire logic [2:0] div_select,
  // Converter clock enable
  output logic            tick
);
  import sar_pkg::*;

  presc_state_type s;
  presc_state_type n;
  logic [6:0]      mask;

  // Codes 0 and 1 both divide by two
  function automatic logic [6:0] div_mask(input logic [2:0] sel);
    logic [7:0] m;
    m = 8'h01;
    if (sel > 3'h1) begin
      m = (8'h01 << sel) - 8'h01;
    end
    return m[6:0];
  endfunction

  always_comb begin
    n = s;
    mask = div_mask(div_select);
    tick = run && !restart && ((s.count & mask) == mask);
    if (!run || restart) begin
      n.count = 7'h00;
    end else begin
      n.count = s.count + 7'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  a_held_in_reset: assert property (@(posedge pclk) disable iff (!presetn)
    !run |=> s.count == 7'h00 && !tick)
    else $error("prescaler not held while disabled");

endmodule

`default_nettype wire

// ### rtl/sar_sequencer.sv
// Successive-approximation conversion sequencer with APB register slave
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "sar_params.svh"

module sar_sequencer
  import sar_pkg::*;
#(
  parameter int ADDR_W = 12
)(
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Trigger sources, index 0 unused
  input  wire logic [7:0]        trig_src,
  // Processor sleep and interrupt handshake
  input  wire logic              cpu_halted,
  input  wire logic              canceler_mode,
  input  wire logic              irq_ack,
  output logic                   conv_irq,
  // Analog front end
  input  wire logic              cmp_above,
  output logic                   analog_enable,
  output logic      [1:0]        channel_mux,
  output logic      [7:0]        dac_code,
  output logic                   sample_hold,
  output logic                   busy
);
  import sar_pkg::*;

  seq_state_type s;
  seq_state_type n;
  logic          tick;
  logic          setup;
  logic          wr;
  logic [7:0]    idx;
  logic          sel_src;
  logic          trig_edge;
  logic          trig_evt;
  logic          sleep_evt;
  logic          start_evt;
  logic          done_evt;
  logic          freerun;
  logic [4:0]    cnt_next;

  function automatic logic [4:0] conv_len(input logic long_c);
    return long_c ? `LEN_FIRST : `LEN_NORMAL;
  endfunction

  function automatic logic [4:0] sh_point(input logic long_c,
                                           input logic auto_c);
    logic [4:0] p;
    p = `SH_NORMAL;
    if (long_c) begin
      p = `SH_FIRST;
    end else if (auto_c) begin
      p = `SH_AUTO;
    end
    return p;
  endfunction

  function automatic logic reg_known(input logic [7:0] i);
    return i == `IDX_RESULT || i == `IDX_CHANNEL ||
           i == `IDX_CTRL_B || i == `IDX_CTRL_A;
  endfunction

  sar_prescaler u_presc (
    .pclk       (pclk),
    .presetn    (presetn),
    .run        (s.converter_enable),
    .restart    (trig_evt),
    .div_select (s.ps),
    .tick       (tick)
  );

  always_comb begin
    n         = s;
    setup     = psel && !penable;
    wr        = psel && penable && s.pready && pwrite;
    idx       = paddr[9:2];
    freerun   = s.ate && s.ts == `SRC_FREERUN;
    sel_src   = (s.ts == `SRC_FREERUN) ? s.flag : trig_src[s.ts];
    trig_edge = s.trig_dly[2] && !s.trig_dly[3];
    start_evt = 1'b0;
    done_evt  = 1'b0;
    cnt_next  = s.cnt + 5'd1;

    // APB: one access cycle, read data captured in setup, write data in access
    n.pready  = setup;
    n.pslverr = 1'b0;
    if (setup) begin
      n.prdata  = `RST_WORD;
      n.pslverr = !reg_known(idx) || paddr[1:0] != 2'b00;
      case (idx)
        `IDX_RESULT:  n.prdata[7:0] = s.result;
        `IDX_CHANNEL: n.prdata[1:0] = s.chan_tmp;
        `IDX_CTRL_B:  n.prdata[2:0] = s.ts;
        `IDX_CTRL_A:  n.prdata[7:0] = {s.converter_enable, s.sc, s.ate, s.flag,
                                       s.ie, s.ps};
        default:      n.prdata      = `RST_WORD;
      endcase
    end

    // Software writes; result register has no write path
    if (wr && paddr[1:0] == 2'b00) begin
      case (idx)
        `IDX_CHANNEL: n.chan_tmp = pwdata[1:0];
        `IDX_CTRL_B:  n.ts       = pwdata[2:0];
        `IDX_CTRL_A: begin
          n.converter_enable = pwdata[`CA_EN];
          n.ate  = pwdata[`CA_ATE];
          n.ie   = pwdata[`CA_IE];
          n.ps   = pwdata[`CA_PS_HI:0];
          if (pwdata[`CA_EN] && !s.converter_enable) begin
            n.first = 1'b1;
          end
          if (pwdata[`CA_SC] && pwdata[`CA_EN]) begin
            n.sc = 1'b1;
          end
          if (pwdata[`CA_FLAG]) begin
            n.flag = 1'b0;
          end
        end
        default: n.ps = n.ps;
      endcase
    end
    if (irq_ack) begin
      n.flag = 1'b0;
    end

    // Three-stage trigger delay, then edge detect
    n.trig_dly = {s.trig_dly[2:0], sel_src};
    trig_evt = s.converter_enable && s.ate && s.ts != `SRC_FREERUN && trig_edge &&
               s.phase == PH_IDLE && !s.sc;
    // Trigger event is the start edge; prescaler restarts with it
    if (trig_evt) begin
      n.sc        = 1'b1;
      n.auto_conv = 1'b1;
      n.phase     = PH_RUN;
      n.cnt       = 5'd0;
      n.long_conv = s.first;
      n.first     = 1'b0;
    end

    // Noise canceler start on processor halt
    n.halt_prev = cpu_halted;
    sleep_evt = cpu_halted && !s.halt_prev && canceler_mode && s.converter_enable &&
                !s.ate && s.phase == PH_IDLE && !s.sc;
    if (sleep_evt) begin
      n.sc = 1'b1;
    end

    // Conversion sequence on converter clock edges
    n.sample = 1'b0;
    if (s.phase == PH_IDLE && s.sc && s.converter_enable && tick) begin
      start_evt   = 1'b1;
      n.phase     = PH_RUN;
      n.cnt       = 5'd0;
      n.long_conv = s.first;
      n.first     = 1'b0;
    end else if (s.phase == PH_RUN && tick) begin
      n.cnt = cnt_next;
      if (cnt_next == sh_point(s.long_conv, s.auto_conv)) begin
        n.sample = 1'b1;
        n.sar    = `SAR_MSB;
        n.mask   = `SAR_MSB;
      end else if (s.mask != 8'h00) begin
        n.sar  = (cmp_above ? s.sar : (s.sar & ~s.mask)) |
                 (s.mask >> 1);
        n.mask = s.mask >> 1;
      end
      if (cnt_next == conv_len(s.long_conv)) begin
        done_evt    = 1'b1;
        n.result    = s.sar;
        n.flag      = 1'b1;
        n.long_conv = 1'b0;
        n.auto_conv = 1'b0;
        n.cnt       = 5'd0;
        if (freerun) begin
          n.phase = PH_RUN;
        end else begin
          n.phase = PH_IDLE;
          n.sc    = 1'b0;
        end
      end
    end

    // Disabling ends any conversion; sleep modes never touch this
    if (!n.converter_enable) begin
      n.phase     = PH_IDLE;
      n.sc        = 1'b0;
      n.cnt       = 5'd0;
      n.mask      = 8'h00;
      n.long_conv = 1'b0;
      n.auto_conv = 1'b0;
    end

    // Channel reload while idle or in last cycle of a conversion
    if (s.phase == PH_IDLE ||
        s.cnt == conv_len(s.long_conv) - 5'd1) begin
      n.chan_act = s.chan_tmp;
    end

    n.irq = n.flag && n.ie;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign prdata        = s.prdata;
  assign pready        = s.pready;
  assign pslverr       = s.pslverr;
  assign conv_irq      = s.irq;
  assign analog_enable = s.converter_enable;
  assign channel_mux   = s.chan_act;
  assign dac_code      = s.sar;
  assign sample_hold   = s.sample;
  assign busy          = s.sc;

  sequence seq_done;
    done_evt ##1 s.flag;
  endsequence

  a_start_on_tick: assert property (@(posedge pclk) disable iff (!presetn)
    start_evt |-> tick && s.sc)
    else $error("conversion started off a converter edge");
  a_normal_len: assert property (@(posedge pclk) disable iff (!presetn)
    done_evt && !s.long_conv |-> s.cnt == `LEN_NORMAL - 5'd1)
    else $error("normal conversion length wrong");
  a_first_len: assert property (@(posedge pclk) disable iff (!presetn)
    done_evt && s.long_conv |-> s.cnt == `LEN_FIRST - 5'd1)
    else $error("first conversion length wrong");
  a_sample_point: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(sample_hold) |-> (s.cnt == `SH_NORMAL || s.cnt == `SH_FIRST ||
                            s.cnt == `SH_AUTO))
    else $error("sample instant wrong");
  a_done_result: assert property (@(posedge pclk) disable iff (!presetn)
    done_evt |-> seq_done ##0 (s.result == $past(s.sar)))
    else $error("result and flag not stored together");
  a_single_clears: assert property (@(posedge pclk) disable iff (!presetn)
    done_evt && !freerun |=> !busy && s.phase == PH_IDLE)
    else $error("start bit not cleared on completion");
  a_freerun_keeps: assert property (@(posedge pclk) disable iff (!presetn)
    done_evt && freerun && n.converter_enable |=> busy && s.phase == PH_RUN)
    else $error("free running did not restart");
  a_chan_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    s.phase == PH_RUN && s.cnt != conv_len(s.long_conv) - 5'd1
    |=> $stable(channel_mux))
    else $error("channel changed mid conversion");
  a_trig_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    s.phase == PH_RUN && trig_edge && !done_evt |-> !trig_evt)
    else $error("trigger accepted during conversion");
  a_flag_ack: assert property (@(posedge pclk) disable iff (!presetn)
    irq_ack && !done_evt |=> !s.flag && !conv_irq)
    else $error("done flag not cleared by acknowledge");

endmodule

`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sar_params.svh"

module tb_top;
  import sar_pkg::*;

  localparam logic [11:0] A_RES = {2'b00, `IDX_RESULT, 2'b00};
  localparam logic [11:0] A_CH  = {2'b00, `IDX_CHANNEL, 2'b00};
  localparam logic [11:0] A_CB  = {2'b00, `IDX_CTRL_B, 2'b00};
  localparam logic [11:0] A_CA  = {2'b00, `IDX_CTRL_A, 2'b00};
  localparam logic [11:0] RA [4] = '{A_RES, A_CH, A_CB, A_CA};
  localparam int          DV [8] = '{2, 2, 4, 8, 16, 32, 64, 128};

  logic        pclk, presetn, psel, penable, pwrite, cmp_above;
  logic        irq_ack, cpu_halted, canceler_mode, se;
  logic        pready, pslverr, conv_irq, analog_enable;
  logic        sample_hold, busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  trig_src, dac_code;
  logic [1:0]  channel_mux;
  logic [7:0]  vin [4];
  int          err_count, comparisons, n1, n2;
  int          dl [2];
  wire logic [3:0] obs = {conv_irq, sample_hold, busy, analog_enable};

  sar_sequencer #(.ADDR_W(12)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trig_src(trig_src),
    .cpu_halted(cpu_halted), .canceler_mode(canceler_mode),
    .irq_ack(irq_ack), .conv_irq(conv_irq), .cmp_above(cmp_above),
    .analog_enable(analog_enable), .channel_mux(channel_mux),
    .dac_code(dac_code), .sample_hold(sample_hold), .busy(busy)
  );

  always #5 pclk = ~pclk;

  // Ideal comparator on the selected input
  always @(posedge pclk) cmp_above <= (vin[channel_mux] >= dac_code);

  task automatic chk(input string nm, input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic rng(input string nm, input int v, lo, hi);
    chk(nm, 32'(v), (v >= lo && v <= hi) ? 32'(v) : 32'(lo));
  endtask

  task automatic end_sim;
    $display("Comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      end_sim();
    end
    rd = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Waits for obs bit b to equal v, counting edges
  task automatic wt(input int b, input logic v, output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (obs[b] !== v && n < 5000);
    if (n >= 5000) begin
      err_count++;
      end_sim();
    end
  endtask

  initial begin
    pclk = 0;
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    trig_src = 0;
    cpu_halted = 0;
    canceler_mode = 0;
    irq_ack = 0;
    vin = '{8'h3c, 8'hc5, 8'h00, 8'hff};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, RA[i], 8'h00);
      chk("reset value", rd, `RST_WORD);
    end
    bus(1'b1, A_RES, 8'h5a);
    bus(1'b0, A_RES, 8'h00);
    chk("result read only", rd, `RST_WORD);
    bus(1'b0, 12'h040, 8'h00);
    chk("unmapped", se, 1'b1);
    // Single conversions over every divider code
    for (int k = 0; k < 8; k++) begin
      int d, ln, sh;
      d = DV[k];
      ln = (k == 0) ? 25 : 13;
      sh = (k == 0) ? 16 : 3;
      bus(1'b1, A_CH, 8'(k % 4));
      bus(1'b1, A_CA, 8'hd0 | 8'(k));
      wt(2, 1'b1, n1);
      wt(1, 1'b0, n2);
      rng("sample", n1, sh * d, sh * d + d + 4);
      rng("finish", n2, (ln - sh) * d - 1, (ln - sh) * d + 1);
      bus(1'b0, A_CA, 8'h00);
      chk("ctrl after done", rd, 32'h90 | k);
      bus(1'b0, A_RES, 8'h00);
      chk("result", rd, vin[k % 4]);
      chk("mux", channel_mux, k % 4);
    end
    // Interrupt and sleep start
    bus(1'b1, A_CA, 8'h88);
    wt(3, 1'b1, n1);
    rng("irq on", n1, 1, 3);
    @(posedge pclk) irq_ack <= 1'b1;
    @(posedge pclk) irq_ack <= 1'b0;
    bus(1'b0, A_CA, 8'h00);
    chk("ack clears", rd, 32'h88);
    canceler_mode <= 1'b1;
    cpu_halted <= 1'b1;
    wt(1, 1'b1, n1);
    rng("sleep start", n1, 1, 8);
    cpu_halted <= 1'b0;
    canceler_mode <= 1'b0;
    wt(1, 1'b0, n2);
    wt(3, 1'b1, n1);
    rng("sleep irq", n1, 1, 3);
    bus(1'b1, A_CA, 8'h98);
    bus(1'b0, A_CA, 8'h00);
    chk("write one clears", rd, 32'h88);
    cpu_halted <= 1'b1;
    repeat (40) @(posedge pclk);
    chk("deep sleep", {analog_enable, busy}, 2'b10);
    cpu_halted <= 1'b0;
    // Free running with a channel change
    bus(1'b1, A_CH, 8'h00);
    bus(1'b1, A_CB, 8'(`SRC_FREERUN));
    bus(1'b1, A_CA, 8'he8);
    wt(3, 1'b1, n1);
    bus(1'b1, A_CH, 8'h01);
    bus(1'b1, A_CA, 8'hf8);
    wt(3, 1'b0, n1);
    wt(3, 1'b1, n1);
    bus(1'b0, A_RES, 8'h00);
    chk("old channel", rd, vin[0]);
    bus(1'b0, A_CA, 8'h00);
    chk("start stays", rd[`CA_SC], 1'b1);
    bus(1'b1, A_CA, 8'hf8);
    wt(3, 1'b0, n1);
    wt(3, 1'b1, n1);
    bus(1'b0, A_RES, 8'h00);
    chk("new channel", rd, vin[1]);
    bus(1'b1, A_CA, 8'h00);
    repeat (2) @(posedge pclk);
    chk("disabled", {analog_enable, busy}, 2'b00);
    // Re-enable uses up the long first conversion before triggering
    bus(1'b1, A_CA, 8'hc3);
    wt(1, 1'b0, n2);
    rng("first again", n2, 25 * 8, 25 * 8 + 9);
    // Auto trigger from source 2, divider 8
    bus(1'b1, A_CB, 8'h02);
    bus(1'b1, A_CA, 8'hb3);
    for (int ph = 0; ph < 2; ph++) begin
      repeat (ph * 3 + 5) @(posedge pclk);
      trig_src[2] <= 1'b1;
      wt(2, 1'b1, n1);
      dl[ph] = n1;
      trig_src[2] <= 1'b0;
      repeat (3) @(posedge pclk);
      trig_src[2] <= 1'b1;
      wt(1, 1'b0, n2);
      repeat (40) @(posedge pclk);
      chk("edge ignored", busy, 1'b0);
      trig_src[2] <= 1'b0;
      bus(1'b1, A_CA, 8'hb3);
      rng("trigger delay", n1, 18, 23);
    end
    chk("fixed delay", dl[0], dl[1]);
    end_sim();
  end
endmodule

`default_nettype wire
